// ==== hdl/pacp_pkg.sv ====
// Constants for the PMA attribute command port: register indices, field
// positions, event bits, attribute codes and timing counts.
// Assumes a 10 MHz register clock; byte address of a register is four times its index.
package pacp_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_HZ              = 10_000_000;
  localparam int ADAPT_BUDGET_MS     = 100;
  localparam int ADAPT_BUDGET_CYCLES = (CLK_HZ / 1000) * ADAPT_BUDGET_MS;
  localparam int EXEC_CYCLES         = 8;

  // ----------------------------------------------------------------------
  // Register indices
  // ----------------------------------------------------------------------
  localparam logic [7:0] IDX_VAL_LO   = 8'h84;
  localparam logic [7:0] IDX_VAL_HI   = 8'h85;
  localparam logic [7:0] IDX_CODE_LO  = 8'h86;
  localparam logic [7:0] IDX_CODE_HI  = 8'h87;
  localparam logic [7:0] IDX_ACCEPT   = 8'h8A;
  localparam logic [7:0] IDX_BUSY     = 8'h8B;
  localparam logic [7:0] IDX_TRIG     = 8'h90;
  localparam logic [7:0] IDX_IRQ_STAT = 8'hA0;
  localparam logic [7:0] IDX_IRQ_CLR  = 8'hA1;
  localparam logic [7:0] IDX_IRQ_EN   = 8'hA2;

  // ----------------------------------------------------------------------
  // Fields, events and reset values
  // ----------------------------------------------------------------------
  localparam int ACCEPT_BIT = 7;
  localparam int BUSY_BIT   = 0;
  localparam int TRIG_BIT   = 0;
  localparam int NUM_EVENTS = 3;
  localparam int EV_ACCEPT  = 0;
  localparam int EV_DONE    = 1;
  localparam int EV_LATE    = 2;
  localparam logic [7:0]  BYTE_RESET = 8'h00;
  localparam logic [15:0] CODE_SELECT = 16'h002C;
  localparam logic [15:0] CODE_WRITE  = 16'h006C;

  // True when a byte address hits the register with the given index.
  function automatic logic reg_hit(input logic [9:0] adr, input logic [7:0] idx);
    reg_hit = (adr[9:2] == idx);
  endfunction

endpackage

// ==== hdl/pacp_engine.sv ====
// Attribute command engine: runs one launched command for a fixed time and
// applies it to the adaptive-engine preset outputs.
// Assumes start_i is a one-cycle pulse given only while busy_o is low.
`timescale 1ns/1ps
module pacp_engine
  import pacp_pkg::*;
#(
  parameter int EXEC = EXEC_CYCLES
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        start_i,
  input  wire logic [15:0] code_i,
  input  wire logic [15:0] value_i,
  output logic             busy_o,
  output logic             done_o,
  output logic [15:0]      param_o,
  output logic [15:0]      value_o,
  output logic             load_o
);

  typedef enum logic {PACP_IDLE, PACP_RUN} pacp_state_type;

  typedef struct packed {
    pacp_state_type state;
    logic [15:0]    cnt;
    logic [15:0]    code;
    logic [15:0]    val;
    logic           done;
    logic [15:0]    param;
    logic [15:0]    out_val;
    logic           load;
  } pacp_eng_type;

  pacp_eng_type st;
  pacp_eng_type next_st;

  // ----------------------------------------------------------------------
  // Sequencing
  // ----------------------------------------------------------------------
  // A select command only names the parameter; every other code writes its
  // value into the parameter selected last.
  always_comb begin
    next_st      = st;
    next_st.done = 1'b0;
    next_st.load = 1'b0;
    unique case (st.state)
      PACP_IDLE: begin
        if (start_i) begin
          next_st.state = PACP_RUN;
          next_st.cnt   = 16'(EXEC - 1);
          next_st.code  = code_i;
          next_st.val   = value_i;
        end
      end
      PACP_RUN: begin
        if (st.cnt == 16'h0000) begin
          next_st.state = PACP_IDLE;
          next_st.done  = 1'b1;
          if (st.code == CODE_SELECT) begin
            next_st.param = st.val;
          end else begin
            next_st.out_val = st.val;
            next_st.load    = 1'b1;
          end
        end else begin
          next_st.cnt = st.cnt - 16'h0001;
        end
      end
    endcase
  end

  // State register.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign busy_o  = (st.state == PACP_RUN);
  assign done_o  = st.done;
  assign param_o = st.param;
  assign value_o = st.out_val;
  assign load_o  = st.load;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  localparam int DONE_MAX = EXEC + 1;

  a_run_done: assert property (@(posedge clk_i) disable iff (rst_i)
    start_i && !busy_o |-> ##[1:DONE_MAX] done_o)
    else $error("Engine did not finish a command in time.");

endmodule

// ==== hdl/pacp_top.sv ====
// PMA attribute command port with a classic Wishbone register slave and a
// sticky interrupt block.
// Assumes one 10 MHz clock, synchronous bus inputs and registers on 32-bit words.
//
// Operation
// - PMA ready within 100 ms budget.
// - Value bytes at attr_value_low_byte low, attr_value_high_byte high.
// - Code bytes at attr_code_low_byte low, attr_code_high_byte high.
// - Writing one to attr_command_trigger bit 0 launches; the code ignores the write while busy.
// - Launch sets acceptance flag attr_accept_flag bit 7.
// - Busy attr_busy_status bit 0 high until completion.
// - Writing one clears acceptance flag.
//
// Implementation choice: register access over Wishbone.
`timescale 1ns/1ps
module pacp_top
  import pacp_pkg::*;
#(
  parameter int BUDGET = ADAPT_BUDGET_CYCLES,
  parameter int EXEC   = EXEC_CYCLES
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [9:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  output logic             irq_o,
  output logic [15:0]      preset_param_o,
  output logic [15:0]      preset_value_o,
  output logic             preset_load_o
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  localparam int WDW = $clog2(BUDGET + 1);

  typedef struct packed {
    logic                  ack;
    logic [7:0]            rdat;
    logic [7:0]            val_lo;
    logic [7:0]            val_hi;
    logic [7:0]            code_lo;
    logic [7:0]            code_hi;
    logic                  accept;
    logic                  start;
    logic [NUM_EVENTS-1:0] stat;
    logic [NUM_EVENTS-1:0] en;
    logic                  irq;
    logic [WDW-1:0]        wd;
    logic                  late;
  } pacp_top_type;

  pacp_top_type st;
  pacp_top_type next_st;

  logic eng_busy;
  logic eng_done;

  // Busy covers the launch cycle too, so a poll right after the trigger
  // write can never see a false completion.
  logic busy_bit;
  assign busy_bit = st.start | eng_busy;

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  logic req;
  logic wr;
  logic launch;
  logic clr_accept;
  assign req        = cyc_i & stb_i & ~st.ack;
  assign wr         = req & we_i & sel_i[0];
  assign launch     = wr & reg_hit(adr_i, IDX_TRIG) & dat_i[TRIG_BIT] & ~busy_bit;
  assign clr_accept = wr & reg_hit(adr_i, IDX_ACCEPT) & dat_i[ACCEPT_BIT];

  // ----------------------------------------------------------------------
  // Read multiplexer
  // ----------------------------------------------------------------------
  // Unmapped addresses answer with zero so the master never hangs.
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    if (reg_hit(adr_i, IDX_VAL_LO)) begin
      rd_mux = st.val_lo;
    end else if (reg_hit(adr_i, IDX_VAL_HI)) begin
      rd_mux = st.val_hi;
    end else if (reg_hit(adr_i, IDX_CODE_LO)) begin
      rd_mux = st.code_lo;
    end else if (reg_hit(adr_i, IDX_CODE_HI)) begin
      rd_mux = st.code_hi;
    end else if (reg_hit(adr_i, IDX_ACCEPT)) begin
      rd_mux[ACCEPT_BIT] = st.accept;
    end else if (reg_hit(adr_i, IDX_BUSY)) begin
      rd_mux[BUSY_BIT] = busy_bit;
    end else if (reg_hit(adr_i, IDX_TRIG)) begin
      rd_mux[TRIG_BIT] = busy_bit;
    end else if (reg_hit(adr_i, IDX_IRQ_STAT)) begin
      rd_mux[NUM_EVENTS-1:0] = st.stat;
    end else if (reg_hit(adr_i, IDX_IRQ_EN)) begin
      rd_mux[NUM_EVENTS-1:0] = st.en;
    end
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  logic [NUM_EVENTS-1:0] events;
  logic [NUM_EVENTS-1:0] clr_mask;
  always_comb begin
    next_st       = st;
    next_st.ack   = req;
    next_st.start = launch;
    events        = '0;
    clr_mask      = '0;
    if (req && !we_i) begin
      next_st.rdat = rd_mux;
    end
    // Attribute value and code are held as separate byte registers.
    if (wr && reg_hit(adr_i, IDX_VAL_LO)) begin
      next_st.val_lo = dat_i[7:0];
    end
    if (wr && reg_hit(adr_i, IDX_VAL_HI)) begin
      next_st.val_hi = dat_i[7:0];
    end
    if (wr && reg_hit(adr_i, IDX_CODE_LO)) begin
      next_st.code_lo = dat_i[7:0];
    end
    if (wr && reg_hit(adr_i, IDX_CODE_HI)) begin
      next_st.code_hi = dat_i[7:0];
    end
    if (wr && reg_hit(adr_i, IDX_IRQ_EN)) begin
      next_st.en = dat_i[NUM_EVENTS-1:0];
    end
    if (wr && reg_hit(adr_i, IDX_IRQ_CLR)) begin
      clr_mask = dat_i[NUM_EVENTS-1:0];
    end
    // Acceptance flag: a launch in the same cycle as a clear wins.
    if (clr_accept) begin
      next_st.accept = 1'b0;
    end
    if (launch) begin
      next_st.accept = 1'b1;
    end
    // Readiness watchdog: a command still busy past the budget is reported.
    if (launch) begin
      next_st.wd   = '0;
      next_st.late = 1'b0;
    end else if (eng_busy && !st.late) begin
      if (st.wd == WDW'(BUDGET - 1)) begin
        next_st.late = 1'b1;
      end else begin
        next_st.wd = st.wd + WDW'(1);
      end
    end
    events[EV_ACCEPT] = launch;
    events[EV_DONE]   = eng_done;
    events[EV_LATE]   = next_st.late & ~st.late;
    // Sticky status: a new event beats a clear of the same bit.
    next_st.stat = (st.stat & ~clr_mask) | events;
    next_st.irq  = |(next_st.stat & next_st.en);
  end

  // State register.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------------
  // Command engine
  // ----------------------------------------------------------------------
  pacp_engine #(
    .EXEC (EXEC)
  ) u_engine (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (st.start),
    .code_i  ({st.code_hi, st.code_lo}),
    .value_i ({st.val_hi, st.val_lo}),
    .busy_o  (eng_busy),
    .done_o  (eng_done),
    .param_o (preset_param_o),
    .value_o (preset_value_o),
    .load_o  (preset_load_o)
  );

  assign dat_o = {24'h000000, st.rdat};
  assign ack_o = st.ack;
  assign irq_o = st.irq;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  localparam int BUSY_MAX = EXEC + 3;

  sequence s_launch;
    launch;
  endsequence

  sequence s_running;
    busy_bit [*2];
  endsequence

  a_accept_set: assert property (s_launch |=> st.accept)
    else $error("Acceptance flag not set by launch.");

  a_accept_clear: assert property (clr_accept && !launch |=> !st.accept)
    else $error("Acceptance flag not cleared by write of one.");

  a_accept_held: assert property (st.accept && !clr_accept |=> st.accept)
    else $error("Acceptance flag lost without a clear.");

  a_busy_runs: assert property (s_launch |=> s_running)
    else $error("Busy did not rise after launch.");

  a_busy_ends: assert property (s_launch |-> ##[2:BUSY_MAX] !busy_bit)
    else $error("Busy did not fall after the command.");

  a_launch_write: assert property (wr && reg_hit(adr_i, IDX_TRIG) && dat_i[TRIG_BIT] && !busy_bit
    |=> st.start)
    else $error("Trigger write did not launch.");

  a_value_low: assert property (wr && reg_hit(adr_i, IDX_VAL_LO) |=> st.val_lo == $past(dat_i[7:0]))
    else $error("Value low byte not stored.");

  a_code_high: assert property (wr && reg_hit(adr_i, IDX_CODE_HI) |=> st.code_hi == $past(dat_i[7:0]))
    else $error("Code high byte not stored.");

  a_late_flag: assert property (eng_busy && !st.late && !launch && st.wd == WDW'(BUDGET - 1)
    |=> st.late && st.stat[EV_LATE])
    else $error("Late command not reported.");

  a_ack_single: assert property (ack_o |=> !ack_o)
    else $error("Acknowledge held longer than one cycle.");

  a_irq_level: assert property (irq_o == |(st.stat & st.en))
    else $error("Interrupt output does not follow enabled status.");

  // Completion and readback. A poll sees the busy and flag values of the cycle
  // in which it was taken, since read data is registered.
  sequence s_done;
    eng_done;
  endsequence

  a_launch_done: assert property (s_launch
    |-> ##[2:BUSY_MAX] s_done)
    else $error("Command did not complete after launch.");

  a_done_status: assert property (s_done
    |=> st.stat[EV_DONE])
    else $error("Completion event not recorded.");

  a_busy_read: assert property (req && !we_i && reg_hit(adr_i, IDX_BUSY)
    |=> dat_o[BUSY_BIT] == $past(busy_bit))
    else $error("Busy readback does not match the running command.");

  a_accept_read: assert property (req && !we_i && reg_hit(adr_i, IDX_ACCEPT)
    |=> dat_o[ACCEPT_BIT] == $past(st.accept))
    else $error("Acceptance flag readback wrong.");

  // Bus handshake and refusal. A trigger during a run must leave the running
  // command untouched, or its code and value could change mid-flight.
  a_ack_answer: assert property (req
    |=> ack_o)
    else $error("Request not acknowledged in the next cycle.");

  a_refuse_busy: assert property (wr && reg_hit(adr_i, IDX_TRIG) && busy_bit
    |=> !st.start && $stable(st.accept))
    else $error("Trigger accepted while a command was running.");

  a_value_high: assert property (wr && reg_hit(adr_i, IDX_VAL_HI)
    |=> st.val_hi == $past(dat_i[7:0]))
    else $error("Value high byte not stored.");

  a_code_low: assert property (wr && reg_hit(adr_i, IDX_CODE_LO)
    |=> st.code_lo == $past(dat_i[7:0]))
    else $error("Code low byte not stored.");

  // Sticky reports: only a clear of that very bit, or a new launch for the
  // late report, may drop them.
  a_stat_sticky: assert property (st.stat[EV_DONE] && !clr_mask[EV_DONE]
    |=> st.stat[EV_DONE])
    else $error("Completion status lost without a clear.");

  a_late_held: assert property (st.late && !launch
    |=> st.late)
    else $error("Late report dropped before the next launch.");

endmodule

// ==== bench/pacp_host.sv ====
// Host model: a classic Wishbone master that loads attribute commands.
// Assumes a single clock and a slave that acks every request once.
`timescale 1ns/1ps
module pacp_host
  import pacp_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] dat_i,
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic [9:0]       adr_o,
  output logic [3:0]       sel_o,
  output logic [31:0]      dat_o
);
  // ----------------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------------
  // Idle bus at time zero.
  initial begin
    {cyc_o, stb_o, we_o} = 3'h0;
    adr_o = 10'h000;
    sel_o = 4'h0;
    dat_o = 32'h0000_0000;
  end

  // One single cycle; released lines show inverted data so stale values never match by luck.
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o  <= w;
    adr_o <= {idx, 2'b00};
    sel_o <= 4'h1;
    dat_o <= {24'h00_0000, d};
    do @(posedge clk_i); while (ack_i !== 1'b1);
    q = dat_i[7:0];
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    dat_o <= ~{24'h00_0000, d};
  endtask

  // ----------------------------------------------------------------------
  // Attribute command
  // ----------------------------------------------------------------------
  // Load both byte pairs, launch, confirm, poll busy, then clear the flag.
  // Only one command is ever outstanding, since this task returns after the clear.
  task automatic command(input logic [15:0] code, input logic [15:0] value,
                         output logic [7:0] acc, output int polls, output logic [7:0] acc_clr);
    logic [7:0] q;
    xfer(1'b1, IDX_VAL_LO, value[7:0], q);
    xfer(1'b1, IDX_VAL_HI, value[15:8], q);
    xfer(1'b1, IDX_CODE_LO, code[7:0], q);
    xfer(1'b1, IDX_CODE_HI, code[15:8], q);
    xfer(1'b1, IDX_TRIG, 8'h01, q);
    xfer(1'b0, IDX_ACCEPT, 8'h00, acc);
    polls = 0;
    do begin
      xfer(1'b0, IDX_BUSY, 8'h00, q);
      polls++;
    end while (q[0] !== 1'b0 && polls < 64);
    xfer(1'b1, IDX_ACCEPT, 8'h80, q);
    xfer(1'b0, IDX_ACCEPT, 8'h00, acc_clr);
  endtask
endmodule

// ==== bench/tb.sv ====
// Testbench for the attribute command port: register access, commands,
// refusal while busy and the interrupt block.
// Assumes the host model and the package constants.
`timescale 1ns/1ps
module tb
  import pacp_pkg::*;
;
  localparam int EXEC_T = 12;
  // Accesses are three cycles apart; the first poll lands six cycles after launch.
  localparam int POLLS = (EXEC_T + 1 - 6 + 2) / 3 + 1;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc, stb, we, ack, irq, load;
  logic [9:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat;
  logic [15:0] p_param, p_value;
  logic [7:0]  q, acc, acc_clr;
  int          n_errors = 0;
  int          checks_done = 0;
  int          polls;
  int          loads = 0;
  logic [7:0]  idx_list [10] = '{8'h84, 8'h85, 8'h86, 8'h87, 8'h8A, 8'h8B, 8'h90, 8'hA0, 8'hA2, 8'h3F};

  always #50 clk_i = ~clk_i;

  // A budget below the run time makes every command overrun, so the late report is exercised.
  pacp_top #(.BUDGET(EXEC_T - 2), .EXEC(EXEC_T)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .irq_o(irq),
    .preset_param_o(p_param), .preset_value_o(p_value), .preset_load_o(load));
  pacp_host u_host (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb), .we_o(we),
    .adr_o(adr), .sel_o(sel), .dat_o(wdat));

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Count preset load pulses; each one must be a single cycle wide.
  always @(posedge clk_i) if (load === 1'b1) loads++;

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    u_host.xfer(1'b1, idx, d, q);
  endtask

  task automatic rd(input logic [7:0] idx);
    u_host.xfer(1'b0, idx, 8'h00, q);
  endtask

  task automatic conclude();
    $display("errors=%0d checks=%0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // A run far longer than the sequence below means the bus hung.
  initial begin
    repeat (4000) @(posedge clk_i);
    n_errors++;
    conclude();
  end

  // ----------------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    // Reset values, unmapped address included.
    foreach (idx_list[i]) begin
      rd(idx_list[i]);
      chk({8'h00, q}, 16'h0000);
    end
    // Byte registers hold what was written.
    for (int i = 0; i < 4; i++) wr(IDX_VAL_LO + 8'(i), 8'hA1 + 8'(i));
    for (int i = 0; i < 4; i++) begin
      rd(IDX_VAL_LO + 8'(i));
      chk({8'h00, q}, {8'h00, 8'hA1 + 8'(i)});
    end
    wr(IDX_IRQ_EN, 8'h07);
    rd(IDX_IRQ_EN);
    chk({8'h00, q}, 16'h0007);
    // Preset selection after a rate change: select, then write the parameter.
    u_host.command(CODE_SELECT, 16'h0118, acc, polls, acc_clr);
    chk({8'h00, acc}, 16'h0080);
    chk(16'(polls), 16'(POLLS));
    chk({8'h00, acc_clr}, 16'h0000);
    chk(p_param, 16'h0118);
    chk(16'(loads), 16'h0000);
    chk({15'h0000, irq}, 16'h0001);
    rd(IDX_IRQ_STAT);
    chk({8'h00, q}, 16'h0007);
    wr(IDX_IRQ_CLR, 8'h07);
    rd(IDX_IRQ_STAT);
    chk({7'h00, irq, q}, 16'h0000);
    wr(IDX_IRQ_EN, 8'h02);
    u_host.command(CODE_WRITE, 16'h0000, acc, polls, acc_clr);
    chk({8'h00, acc}, 16'h0080);
    chk({p_value, 15'h0000, 1'(loads)}, {16'h0000, 16'h0001});
    // A trigger while busy is refused; the masked accept event keeps irq low.
    wr(IDX_IRQ_CLR, 8'h07);
    wr(IDX_VAL_LO, 8'h55);
    wr(IDX_VAL_HI, 8'hAA);
    wr(IDX_TRIG, 8'h01);
    wr(IDX_ACCEPT, 8'h80);
    chk({15'h0000, irq}, 16'h0000);
    wr(IDX_TRIG, 8'h01);
    rd(IDX_ACCEPT);
    chk({8'h00, q}, 16'h0000);
    rd(IDX_BUSY);
    chk({8'h00, q}, 16'h0001);
    repeat (EXEC_T) @(posedge clk_i);
    rd(IDX_BUSY);
    chk({8'h00, q}, 16'h0000);
    chk(p_value, 16'hAA55);
    chk(16'(loads), 16'h0002);
    chk({15'h0000, irq}, 16'h0001);
    rd(IDX_IRQ_STAT);
    chk({8'h00, q}, 16'h0007);
    conclude();
  end
endmodule
